//--- shared/qep_pkg.sv
// package for the quadrature encoder position block
// assumes a plain register port and a single 40 MHz clock
package qep_pkg;
    // register offsets (word addresses on the plain port)
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_LIMIT = 4'h1;
    localparam logic [3:0] ADDR_POS = 4'h2;
    localparam logic [3:0] ADDR_STAT = 4'h3;
    localparam logic [3:0] ADDR_MASK = 4'h4;
    localparam logic [3:0] ADDR_RAW = 4'h5;
    localparam logic [3:0] ADDR_MIS = 4'h6;
    localparam logic [3:0] ADDR_CLR = 4'h7;
    // control field positions
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_BOTH = 1;
    localparam int CTRL_IDXRST = 2;
    localparam int CTRL_STEPDIR = 3;
    localparam int CTRL_SWAP = 4;
    localparam int CTRL_W = 5;
    // status field positions
    localparam int STAT_DIR = 0;
    localparam int STAT_ERR = 1;
    // interrupt source bits
    localparam int EV_ERR = 0;
    localparam int EV_DIR = 1;
    localparam int EV_TIMER = 2;
    localparam int EV_INDEX = 3;
    localparam int EV_N = 4;
    // reset values
    localparam logic [31:0] LIMIT_RST = 32'hFFFFFFFF;
    // configuration carried as one bundle
    typedef struct packed {
        logic swap;
        logic step_dir;
        logic idx_rst;
        logic both;
        logic enable;
    } qep_cfg_t;
    // synchronised encoder pins
    typedef struct packed {
        logic a;
        logic b;
        logic idx;
    } qep_pins_t;
endpackage

//--- logic/qep_top.sv
// quadrature encoder position tracker with register port and events
// assumes encoder pins asynchronous to clock_in, one 40 MHz clock
// and software that configures the block before enabling it
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
module qep_top #(
    parameter int POS_W = 32
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic encoder_channel_a_in,
    input wire logic encoder_channel_b_in,
    input wire logic index_in,
    input wire logic velocity_period_event_in,
    input wire logic [3:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    output logic irq_out,
    output logic count_edge_out
);
    // refuse position widths that the register port cannot carry
    if (POS_W < 2 || POS_W > 32) begin : g_bad_pos_w
        $error("qep_top: POS_W must be 2..32");
    end

    ////////////////////////////////////////////////////////////////////
    // registers
    qep_pkg::qep_cfg_t cfg;
    logic [POS_W-1:0] limit;
    logic [POS_W-1:0] pos;
    logic dir_rev;
    logic phase_err;
    logic [qep_pkg::EV_N-1:0] raw;
    logic [qep_pkg::EV_N-1:0] mask;
    logic [qep_pkg::EV_N-1:0] ev;

    ////////////////////////////////////////////////////////////////////
    // three-stage pin synchronisers; change counts when stages 2 and 3 agree
    qep_pkg::qep_pins_t s1, s2, s3, pin;
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end else begin
            s1 <= '{a: encoder_channel_a_in, b: encoder_channel_b_in, idx: index_in};
            s2 <= s1;
            s3 <= s2;
        end
    end

    // filtered pins follow only when two stages agree
    // a pulse of one clock never reaches the decoder
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            pin <= '0;
        end else begin
            if (s2.a == s3.a) pin.a <= s3.a;
            if (s2.b == s3.b) pin.b <= s3.b;
            if (s2.idx == s3.idx) pin.idx <= s3.idx;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // decode
    logic in_a, in_b, prev_a, prev_b, prev_idx;
    logic edge_a, edge_b, idx_rise, step, rev_now, dir_valid;
    always_comb begin
        in_a = cfg.swap ? pin.b : pin.a;
        in_b = cfg.swap ? pin.a : pin.b;
    end

    // previous sample of the decoded inputs
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            prev_a <= 1'b0;
            prev_b <= 1'b0;
            prev_idx <= 1'b0;
        end else begin
            prev_a <= in_a;
            prev_b <= in_b;
            prev_idx <= pin.idx;
        end
    end

    // edge selection and direction per input mode
    always_comb begin
        edge_a = in_a ^ prev_a;
        edge_b = in_b ^ prev_b;
        idx_rise = pin.idx & ~prev_idx & cfg.enable;
        step = 1'b0;
        rev_now = dir_rev;
        dir_valid = 1'b0;
        if (cfg.step_dir) begin
            step = in_a & ~prev_a; // rising step clock
            rev_now = in_b; // level on b is direction
            dir_valid = step;
        end else if (!(edge_a && edge_b)) begin
            if (edge_a) begin
                step = 1'b1;
                rev_now = (in_a == in_b);
                dir_valid = 1'b1;
            end else if (edge_b) begin
                step = cfg.both;
                rev_now = (in_a != in_b);
                dir_valid = 1'b1;
            end
        end
        step = step & cfg.enable;
        dir_valid = dir_valid & cfg.enable;
    end

    ////////////////////////////////////////////////////////////////////
    // position integrator
    // an index load wins over a step in the same cycle
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            pos <= '0;
        end else if (idx_rise && cfg.idx_rst) begin
            pos <= rev_now ? limit : '0;
        end else if (step) begin
            if (!rev_now) begin
                pos <= (pos >= limit) ? '0 : pos + 1'b1;
            end else begin
                pos <= (pos == '0) ? limit : pos - 1'b1;
            end
        end
    end

    // direction and error indicator
    // an error in the same cycle as its clear write keeps the flag set
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            dir_rev <= 1'b0;
            phase_err <= 1'b0;
        end else begin
            if (dir_valid) dir_rev <= rev_now;
            if (cfg.enable && !cfg.step_dir && edge_a && edge_b) phase_err <= 1'b1;
            else if (wr_in && addr_in == qep_pkg::ADDR_STAT && wdata_in[qep_pkg::STAT_ERR]) phase_err <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // events and interrupt latches; a new event beats a clear
    // every source is gated by enable, so a stopped block latches nothing
    always_comb begin
        ev = '0;
        ev[qep_pkg::EV_ERR] = cfg.enable & ~cfg.step_dir & edge_a & edge_b;
        ev[qep_pkg::EV_DIR] = dir_valid & (rev_now != dir_rev);
        ev[qep_pkg::EV_TIMER] = velocity_period_event_in & cfg.enable;
        ev[qep_pkg::EV_INDEX] = idx_rise;
    end

    genvar gi;
    generate
        for (gi = 0; gi < qep_pkg::EV_N; gi++) begin : g_ev
            always_ff @(posedge clock_in or posedge rst_in) begin
                if (rst_in) begin
                    raw[gi] <= 1'b0;
                end else if (ev[gi]) begin
                    raw[gi] <= 1'b1;
                end else if (wr_in && addr_in == qep_pkg::ADDR_CLR && wdata_in[gi]) begin
                    raw[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // masked interrupt output
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            irq_out <= 1'b0;
            count_edge_out <= 1'b0;
        end else begin
            irq_out <= |(raw & mask);
            count_edge_out <= step; // feeds velocity accumulator
        end
    end

    ////////////////////////////////////////////////////////////////////
    // register writes; software configures before enabling
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            cfg <= '0;
            limit <= qep_pkg::LIMIT_RST[POS_W-1:0];
            mask <= '0;
        end else if (wr_in) begin
            if (addr_in == qep_pkg::ADDR_CTRL) begin
                cfg <= wdata_in[qep_pkg::CTRL_W-1:0];
            end else if (addr_in == qep_pkg::ADDR_LIMIT) begin
                limit <= wdata_in[POS_W-1:0];
            end else if (addr_in == qep_pkg::ADDR_MASK) begin
                mask <= wdata_in[qep_pkg::EV_N-1:0];
            end
        end
    end

    // status word built from the named field positions
    logic [31:0] stat_word;
    always_comb begin
        stat_word = '0;
        stat_word[qep_pkg::STAT_DIR] = dir_rev;
        stat_word[qep_pkg::STAT_ERR] = phase_err;
    end

    // read data in the cycle after the strobe
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_out <= '0;
        end else if (rd_in) begin
            if (addr_in == qep_pkg::ADDR_CTRL) rdata_out <= 32'(cfg);
            else if (addr_in == qep_pkg::ADDR_LIMIT) rdata_out <= 32'(limit);
            else if (addr_in == qep_pkg::ADDR_POS) rdata_out <= 32'(pos);
            else if (addr_in == qep_pkg::ADDR_STAT) rdata_out <= stat_word;
            else if (addr_in == qep_pkg::ADDR_MASK) rdata_out <= 32'(mask);
            else if (addr_in == qep_pkg::ADDR_RAW) rdata_out <= 32'(raw);
            else if (addr_in == qep_pkg::ADDR_MIS) rdata_out <= 32'(raw & mask);
            else rdata_out <= 32'h00000000;
        end else begin
            rdata_out <= 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // assertions
    // interrupt output follows the masked latches one cycle late
    a_irq_masked: assert property (@(posedge clock_in) disable iff (rst_in)
        ((raw & mask) == '0) |=> !irq_out) else $error("irq without unmasked source");
    a_irq_raise: assert property (@(posedge clock_in) disable iff (rst_in)
        ((raw & mask) != '0) |=> irq_out) else $error("irq missing");
    a_timer_event: assert property (@(posedge clock_in) disable iff (rst_in)
        (velocity_period_event_in && cfg.enable) |=> raw[qep_pkg::EV_TIMER]) else $error("timer event lost");
    a_clr_works: assert property (@(posedge clock_in) disable iff (rst_in)
        (wr_in && addr_in == qep_pkg::ADDR_CLR && wdata_in[qep_pkg::EV_INDEX] && !ev[qep_pkg::EV_INDEX])
        |=> !raw[qep_pkg::EV_INDEX]) else $error("clear ignored");
    a_event_sets: assert property (@(posedge clock_in) disable iff (rst_in)
        ev[qep_pkg::EV_DIR] |=> raw[qep_pkg::EV_DIR]) else $error("event lost");

    // position integrator
    a_disabled_still: assert property (@(posedge clock_in) disable iff (rst_in)
        !cfg.enable |=> $stable(pos)) else $error("pos moved while disabled");
    a_idx_fwd_zero: assert property (@(posedge clock_in) disable iff (rst_in)
        (idx_rise && cfg.idx_rst && !rev_now) |=> pos == '0) else $error("index no zero");
    a_idx_rev_limit: assert property (@(posedge clock_in) disable iff (rst_in)
        (idx_rise && cfg.idx_rst && rev_now) |=> pos == $past(limit)) else $error("index no limit");
    a_no_idx_reset: assert property (@(posedge clock_in) disable iff (rst_in)
        (!cfg.idx_rst && !step) |=> $stable(pos)) else $error("pos reset without option");
    a_count_up: assert property (@(posedge clock_in) disable iff (rst_in)
        (step && !rev_now && pos < limit && !(idx_rise && cfg.idx_rst)) |=> pos == $past(pos) + 1'b1)
        else $error("no forward count");
    a_wrap_fwd: assert property (@(posedge clock_in) disable iff (rst_in)
        (step && !rev_now && pos == limit && !(idx_rise && cfg.idx_rst)) |=> pos == '0)
        else $error("no forward wrap");
    a_wrap_rev: assert property (@(posedge clock_in) disable iff (rst_in)
        (step && rev_now && pos == '0 && !(idx_rise && cfg.idx_rst)) |=> pos == $past(limit))
        else $error("no reverse wrap");

    // decoding, direction, error and read port
    a_chan_a_only: assert property (@(posedge clock_in) disable iff (rst_in)
        (!cfg.step_dir && !cfg.both && edge_b && !edge_a) |-> !step) else $error("channel b counted");
    a_edge_pulse: assert property (@(posedge clock_in) disable iff (rst_in)
        1'b1 |=> (count_edge_out == $past(step))) else $error("edge pulse wrong");
    a_step_level: assert property (@(posedge clock_in) disable iff (rst_in)
        (cfg.step_dir && step) |-> (rev_now == in_b)) else $error("step direction wrong");
    a_dir_held: assert property (@(posedge clock_in) disable iff (rst_in)
        !dir_valid |=> $stable(dir_rev)) else $error("direction moved");
    a_error_sticky: assert property (@(posedge clock_in) disable iff (rst_in)
        ev[qep_pkg::EV_ERR] |=> phase_err) else $error("error flag missed");
    a_err_clear: assert property (@(posedge clock_in) disable iff (rst_in)
        (wr_in && addr_in == qep_pkg::ADDR_STAT && wdata_in[qep_pkg::STAT_ERR] && !ev[qep_pkg::EV_ERR])
        |=> !phase_err) else $error("error clear ignored");
    a_rdata_idle: assert property (@(posedge clock_in) disable iff (rst_in)
        !rd_in |=> (rdata_out == '0)) else $error("read data without strobe");

    // main scenarios reached
    c_step: cover property (@(posedge clock_in) disable iff (rst_in) step ##[1:12] step);
    c_irq: cover property (@(posedge clock_in) disable iff (rst_in) irq_out);
    c_idx: cover property (@(posedge clock_in) disable iff (rst_in) idx_rise && cfg.idx_rst);
    c_err: cover property (@(posedge clock_in) disable iff (rst_in) ev[qep_pkg::EV_ERR]);
    c_wrap_rev: cover property (@(posedge clock_in) disable iff (rst_in) step && rev_now && pos == '0);
endmodule

//--- test/qep_enc_model.sv
// encoder model: gray-code phases, raw pin levels and index
// assumes its tasks are called from the bench on clk_in
`timescale 1ns/1ps
module qep_enc_model (
    input wire logic clk_in,
    output logic a_out,
    output logic b_out,
    output logic idx_out
);
    int s = 0;
    // pins idle low
    initial begin
        a_out = 1'b0;
        b_out = 1'b0;
        idx_out = 1'b0;
    end
    ////////////////////////////////////////////////////////////////
    // one gray step per call, a leads b going forward
    task automatic move(input bit fwd, input int gap);
        s = fwd ? (s + 1) % 4 : (s + 3) % 4;
        set(s == 1 || s == 2, s >= 2, 1'b0, gap);
    endtask
    // drive raw levels after an edge, hold them gap cycles
    task automatic set(input logic a, input logic b, input logic i, input int gap);
        @(posedge clk_in);
        a_out <= a;
        b_out <= b;
        idx_out <= i;
        repeat (gap) @(posedge clk_in);
    endtask
endmodule

//--- test/tb.sv
// testbench: register port, encoder traffic and events vs a bench model
// assumes qep_pkg, qep_top and qep_enc_model are compiled first
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic vel = 1'b0;
    logic a, b, idx, irq, edge_p;
    logic [31:0] rdata, r;
    logic [31:0] pos = 32'h0;
    logic [31:0] lim = 32'h5;
    logic [4:0] modes[4] = '{5'h03, 5'h01, 5'h13, 5'h11};
    bit rev, en, both, swp, irst;
    int mismatches = 0;
    int n_tests = 0;
    int n_edge = 0;
    int exp_edge = 0;
    int cycles = 0;
    always #12.5 clk = ~clk;
    qep_top dut (.clock_in(clk), .rst_in(rst), .encoder_channel_a_in(a), .encoder_channel_b_in(b),
        .index_in(idx), .velocity_period_event_in(vel), .addr_in(addr), .wdata_in(wdata),
        .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .irq_out(irq), .count_edge_out(edge_p));
    qep_enc_model enc (.clk_in(clk), .a_out(a), .b_out(b), .idx_out(idx));
    ////////////////////////////////////////////////////////////////
    // count velocity-feed pulses and cut a hang short
    always @(posedge clk) begin
        cycles++;
        if (edge_p === 1'b1) n_edge++;
        if (cycles == 20000) begin
            mismatches++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // interrupt level, looked at once it has settled after the edge
    task automatic chk_irq(input logic e);
        #1;
        chk({31'h0, irq}, {31'h0, e});
    endtask
    ////////////////////////////////////////////////////////////////
    // register port master
    task automatic wreg(input logic [3:0] ad, input logic [31:0] d);
        @(posedge clk);
        addr <= ad;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rchk(input logic [3:0] ad, input logic [31:0] m, input logic [31:0] e);
        @(posedge clk);
        addr <= ad;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 r = rdata;
        chk(r & m, e);
    endtask
    // options first, enable after
    task automatic cfg(input logic [4:0] c);
        wreg(qep_pkg::ADDR_CTRL, {27'h0, c & 5'h1E});
        wreg(qep_pkg::ADDR_CTRL, {27'h0, c});
        {swp, irst, both, en} = {c[4], c[2], c[1], c[0]};
    endtask
    ////////////////////////////////////////////////////////////////
    // bench model of the position integrator
    task automatic mstep(input bit f);
        rev = !f;
        exp_edge++;
        if (f) pos = (pos >= lim) ? 32'h0 : pos + 32'h1;
        else pos = (pos == 32'h0) ? lim : pos - 32'h1;
    endtask
    task automatic go(input bit fwd, input int n);
        bit a0;
        bit a1;
        // the decoded channel a is the physical b pin when swapped
        for (int i = 0; i < n; i++) begin
            a0 = swp ? (enc.s >= 2) : (enc.s == 1 || enc.s == 2);
            enc.move(fwd, 6 + $urandom % 5);
            a1 = swp ? (enc.s >= 2) : (enc.s == 1 || enc.s == 2);
            if (en && (both || a0 != a1)) mstep(fwd ^ swp);
        end
    endtask
    task automatic stp(input bit r1, input int n);
        enc.set(1'b0, r1, 1'b0, 8);
        for (int i = 0; i < n; i++) begin
            enc.set(1'b1, r1, 1'b0, 8);
            enc.set(1'b0, r1, 1'b0, 8);
            mstep(!r1);
        end
        enc.set(1'b0, 1'b0, 1'b0, 8);
    endtask
    task automatic idxp();
        enc.set(1'b0, 1'b0, 1'b1, 8);
        enc.set(1'b0, 1'b0, 1'b0, 8);
        if (en && irst) pos = rev ? lim : 32'h0;
    endtask
    ////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        void'($urandom(75188));
        lim = 32'h3 + 32'($urandom % 5);
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rchk(qep_pkg::ADDR_LIMIT, '1, qep_pkg::LIMIT_RST);
        rchk(qep_pkg::ADDR_POS, '1, 32'h0);
        rchk(4'hC, '1, 32'h0);
        wreg(qep_pkg::ADDR_LIMIT, lim);
        foreach (modes[k]) begin
            cfg(modes[k]);
            go(1, 4 * (1 + $urandom % 3));
            rchk(qep_pkg::ADDR_POS, '1, pos);
            go(0, 4 * (2 + $urandom % 3));
            rchk(qep_pkg::ADDR_POS, '1, pos);
            rchk(qep_pkg::ADDR_STAT, '1, {31'h0, rev});
        end
        rchk(qep_pkg::ADDR_RAW, 32'h2, 32'h2);
        cfg(5'h02);
        go(1, 4);
        rchk(qep_pkg::ADDR_POS, '1, pos);
        cfg(5'h09);
        stp(1'b0, 3);
        stp(1'b1, 5);
        rchk(qep_pkg::ADDR_POS, '1, pos);
        repeat (30) @(posedge clk);
        rchk(qep_pkg::ADDR_STAT, '1, 32'h1);
        cfg(5'h05);
        go(0, 4);
        idxp();
        rchk(qep_pkg::ADDR_POS, '1, pos);
        go(1, 4);
        idxp();
        rchk(qep_pkg::ADDR_POS, '1, pos);
        cfg(5'h01);
        go(1, 4);
        idxp();
        rchk(qep_pkg::ADDR_POS, '1, pos);
        rchk(qep_pkg::ADDR_RAW, 32'h8, 32'h8);
        wreg(qep_pkg::ADDR_CLR, 32'hF);
        enc.set(1'b1, 1'b1, 1'b0, 8);
        enc.set(1'b0, 1'b0, 1'b0, 8);
        rchk(qep_pkg::ADDR_POS, '1, pos);
        rchk(qep_pkg::ADDR_STAT, '1, {30'h0, 1'b1, rev});
        rchk(qep_pkg::ADDR_RAW, 32'h1, 32'h1);
        wreg(qep_pkg::ADDR_STAT, 32'h2);
        rchk(qep_pkg::ADDR_STAT, '1, {31'h0, rev});
        wreg(qep_pkg::ADDR_CLR, 32'hF);
        wreg(qep_pkg::ADDR_MASK, 32'h4);
        @(posedge clk) vel <= 1'b1;
        @(posedge clk) vel <= 1'b0;
        repeat (3) @(posedge clk);
        chk_irq(1'b1);
        rchk(qep_pkg::ADDR_MIS, '1, 32'h4);
        rchk(qep_pkg::ADDR_RAW, '1, 32'h4);
        wreg(qep_pkg::ADDR_MASK, 32'h0);
        repeat (3) @(posedge clk);
        chk_irq(1'b0);
        wreg(qep_pkg::ADDR_MASK, 32'h4);
        wreg(qep_pkg::ADDR_CLR, 32'h4);
        repeat (3) @(posedge clk);
        chk_irq(1'b0);
        rchk(qep_pkg::ADDR_RAW, '1, 32'h0);
        chk(32'(n_edge), 32'(exp_edge));
        stop_test();
    end
endmodule
